// ==== logic/boot_select.sv ====
/*
  Startup selector run after every reset: counts external reset presses,
  picks user program or loader, times the loader out and keeps the
  brown-out flag. Assumes command-start, exit and program-valid strobes
  come from the USB/loader logic on the same clock; the pin is async.
*/
`timescale 1ns/100ps
module boot_select #(
  parameter int unsigned WINDOW_CYCLES   = boot_select_pkg::WINDOW_CYCLES,
  parameter int unsigned LOADER_CYCLES   = boot_select_pkg::LOADER_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = boot_select_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned FADE_CYCLES     = boot_select_pkg::FADE_STEP_CYCLES
) (
  input  wire logic        sys_clk_in,             // System clock, 20 MHz
  input  wire logic        reset_in,               // Synchronous reset, high
  input  wire logic        power_on_reset_in,      // Power-on clear of reset cause
  input  wire logic        ext_reset_n_in,         // External reset line, async
  input  wire logic        cmd_start_in,           // Programming command began
  input  wire logic        loader_exit_in,         // Loader asks to leave
  input  wire logic        user_program_valid_in,  // User image present
  input  wire logic        brownout_event_in,      // Brown-out detected pulse
  input  wire logic        brownout_clear_in,      // User program clears flag
  output logic             cpu_hold_out,           // User code held off
  output logic             run_user_out,           // User program running
  output logic             loader_active_out,      // Loader mode active
  output logic [14:0]      fetch_base_out,         // Program fetch base
  output logic [1:0]       serial_port_count_out,  // Serial ports offered
  output logic             usb_serial_enable_out,  // Loader serial port on
  output logic             led_out,                // Indicator LED
  output logic             brownout_reset_flag_out // Reset cause: brown-out
);

  typedef struct packed {
    logic [2:0]                          sync;
    logic                                filt;
    logic [boot_select_pkg::DEB_W-1:0]   deb;
    logic                                fall;
    boot_select_pkg::boot_state_e        st;
    logic [boot_select_pkg::CNT_W-1:0]   cnt;
    logic                                cmd_seen;
    logic                                bo_flag;
    logic                                hold;
    logic                                run_user;
    logic                                loader;
    logic [boot_select_pkg::ADDR_W-1:0]  base;
    logic [1:0]                          ports;
  } sel_s;

  sel_s q, d;

  always_comb begin
    d = q;
    // pin synchroniser
    // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2
    d.sync = {q.sync[1:0], ext_reset_n_in};

    // debounce filter
    // Level must stay agreed and changed for the whole debounce time
    if ((q.sync[1] == q.sync[2]) && (q.sync[2] != q.filt)) begin
      if (q.deb == boot_select_pkg::DEB_W'(DEBOUNCE_CYCLES - 1)) begin
        d.filt = q.sync[2];
        d.deb = '0;
      end else begin
        d.deb = q.deb + 1'b1;
      end
    end else begin
      d.deb = '0;
    end

    d.fall = q.filt & ~d.filt;

    // Default count down of the running timer
    if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end

    case (q.st)
      // decide before user code
      // Reset itself counts as the first press
      boot_select_pkg::ST_START: begin
        d.st = boot_select_pkg::ST_WINDOW;
        d.cnt = boot_select_pkg::CNT_W'(WINDOW_CYCLES - 1);
      end
      boot_select_pkg::ST_WINDOW: begin
        if (q.fall) begin
          d.st = boot_select_pkg::ST_LOADER;
          d.cnt = boot_select_pkg::CNT_W'(LOADER_CYCLES - 1);
          d.cmd_seen = 1'b0;
        end else if (q.cnt == '0) begin
          d.st = user_program_valid_in ? boot_select_pkg::ST_USER
                                       : boot_select_pkg::ST_LOADER;
          d.cnt = boot_select_pkg::CNT_W'(LOADER_CYCLES - 1);
          d.cmd_seen = 1'b0;
        end
      end
      boot_select_pkg::ST_LOADER: begin
        if (cmd_start_in) begin
          d.cmd_seen = 1'b1;
        end
        if (q.fall) begin
          d.st = boot_select_pkg::ST_WINDOW;
          d.cnt = boot_select_pkg::CNT_W'(WINDOW_CYCLES - 1);
        end else if (loader_exit_in && user_program_valid_in) begin
          d.st = boot_select_pkg::ST_USER;
        end else if ((q.cnt == '0) && !q.cmd_seen && !cmd_start_in
                     && user_program_valid_in) begin
          d.st = boot_select_pkg::ST_USER;
        end else if (!user_program_valid_in) begin
          d.cnt = boot_select_pkg::CNT_W'(LOADER_CYCLES - 1);
        end
      end
      boot_select_pkg::ST_USER: begin
        // A new press restarts the whole selection
        if (q.fall) begin
          d.st = boot_select_pkg::ST_WINDOW;
          d.cnt = boot_select_pkg::CNT_W'(WINDOW_CYCLES - 1);
        end
      end
      default: begin
        d.st = boot_select_pkg::ST_START;
      end
    endcase

    // Registered mode outputs follow the next state
    d.hold = (d.st != boot_select_pkg::ST_USER);
    d.run_user = (d.st == boot_select_pkg::ST_USER);
    d.loader = (d.st == boot_select_pkg::ST_LOADER);
    d.base = d.loader ? boot_select_pkg::LOADER_BASE : boot_select_pkg::USER_BASE;
    d.ports = d.loader ? boot_select_pkg::LOADER_PORTS : boot_select_pkg::NO_PORTS;

    // brown-out flag set and clear
    // Only the user program or power-on clears it; a new event wins over the clear
    if (brownout_event_in) begin
      d.bo_flag = 1'b1;
    end else if (brownout_clear_in) begin
      d.bo_flag = 1'b0;
    end
  end

  // Ordinary reset keeps the reset cause; of the two resets only power-on clears it
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || power_on_reset_in) begin
      q <= '0;
      q.sync <= boot_select_pkg::SYNC_IDLE;
      q.filt <= 1'b1;
      q.st <= boot_select_pkg::ST_START;
      q.hold <= 1'b1;
      q.base <= boot_select_pkg::USER_BASE;
      q.ports <= boot_select_pkg::NO_PORTS;
      q.bo_flag <= power_on_reset_in ? 1'b0 : (q.bo_flag | brownout_event_in);
    end else begin
      q <= d;
    end
  end

  led_fader #(
    .STEP_CYCLES (FADE_CYCLES)
  ) u_fader (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .enable_in  (q.loader),
    .led_out    (led_out)
  );

  assign cpu_hold_out            = q.hold;
  assign run_user_out            = q.run_user;
  assign loader_active_out       = q.loader;
  assign fetch_base_out          = q.base;
  assign serial_port_count_out   = q.ports;
  assign usb_serial_enable_out   = q.loader;
  assign brownout_reset_flag_out = q.bo_flag;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in || power_on_reset_in);

  sequence window_press_s;
    (q.st == boot_select_pkg::ST_WINDOW) && q.fall;
  endsequence

  sequence window_quiet_end_s;
    (q.st == boot_select_pkg::ST_WINDOW) && !q.fall && (q.cnt == '0);
  endsequence

  startup_hold_a: assert property (q.st != boot_select_pkg::ST_USER |-> cpu_hold_out)
    else $error("User code released before selection finished");

  window_expire_a: assert property (window_quiet_end_s ##0 user_program_valid_in
      |=> run_user_out && !cpu_hold_out)
    else $error("Quiet window did not start the user program");

  double_press_a: assert property (window_press_s |=> loader_active_out ##1 loader_active_out)
    else $error("Second press did not enter loader");

  loader_timeout_a: assert property ((q.st == boot_select_pkg::ST_LOADER) && (q.cnt == '0)
      && !q.cmd_seen && !cmd_start_in && !q.fall && user_program_valid_in
      |=> run_user_out)
    else $error("Idle loader did not time out to user");

  empty_image_a: assert property ((q.st == boot_select_pkg::ST_LOADER) && !q.fall
      && !user_program_valid_in |=> loader_active_out)
    else $error("Loader left with no valid user program");

  fetch_split_a: assert property (run_user_out |-> fetch_base_out == boot_select_pkg::USER_BASE
      && !usb_serial_enable_out)
    else $error("User mode fetching from loader area");

  one_port_a: assert property ($rose(loader_active_out) |->
      serial_port_count_out == boot_select_pkg::LOADER_PORTS
      && fetch_base_out == boot_select_pkg::LOADER_BASE)
    else $error("Loader port count or base wrong");

  brownout_keep_a: assert property (brownout_reset_flag_out && !brownout_clear_in
      |=> brownout_reset_flag_out)
    else $error("Brown-out flag lost without user clear");

  brownout_set_a: assert property (brownout_event_in |=> brownout_reset_flag_out)
    else $error("Brown-out event not recorded");

  single_edge_a: assert property (q.fall |=> !q.fall ##1 !q.fall)
    else $error("One press counted more than once");

endmodule

// ==== logic/boot_select_pkg.sv ====
/*
  Constants, state encoding and timing for the double-reset boot selector.
  Assumes a single 20 MHz system clock and a 32 KB program memory.
*/
// How it works
// - Selector decides before any user code runs
// - Single reset: user program after 750 ms
// - Second reset within 750 ms: loader mode
// - Loader idle 8 s: back to user
// - LED fades in and out in loader
// - Loader top 4 KB, user low 28 KB
// - Loader offers exactly one serial port
// - Brown-out flag kept for user program
// - No valid user program: stay in loader
package boot_select_pkg;

  // Clock and printed times
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned WINDOW_MS    = 750;
  localparam int unsigned LOADER_S     = 8;
  localparam int unsigned DEBOUNCE_US  = 1000;
  localparam int unsigned FADE_STEP_US = 2000;

  // Derived cycle counts
  localparam int unsigned WINDOW_CYCLES    = WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned LOADER_CYCLES    = LOADER_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FADE_STEP_CYCLES = FADE_STEP_US * (CLK_HZ / 1_000_000);

  // Counter widths
  localparam int unsigned CNT_W  = 28;
  localparam int unsigned DEB_W  = 16;
  localparam int unsigned FADE_W = 16;

  // Program memory split, byte addresses
  localparam int unsigned ADDR_W       = 15;
  localparam int unsigned MEM_BYTES    = 32768;
  localparam int unsigned LOADER_BYTES = 4096;
  localparam int unsigned USER_BYTES   = MEM_BYTES - LOADER_BYTES;
  localparam logic [14:0] USER_BASE    = 15'h0000;
  localparam logic [14:0] LOADER_BASE  = 15'h7000;

  // Serial ports presented in each mode
  localparam logic [1:0] LOADER_PORTS = 2'h1;
  localparam logic [1:0] NO_PORTS     = 2'h0;

  // Sync chain reset value: line idles high
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  // LED brightness limits
  localparam logic [7:0] LEVEL_MAX = 8'hff;
  localparam logic [7:0] LEVEL_MIN = 8'h00;

  // Gray-coded path: start, window, loader, user
  typedef enum logic [1:0] {
    ST_START  = 2'h0,
    ST_WINDOW = 2'h1,
    ST_LOADER = 2'h3,
    ST_USER   = 2'h2
  } boot_state_e;

endpackage

// ==== logic/led_fader.sv ====
/*
  Triangle-ramp PWM driver for the mode indicator LED.
  Assumes the enable comes from logic on the same clock.
*/
`timescale 1ns/100ps
module led_fader #(
  parameter int unsigned STEP_CYCLES = boot_select_pkg::FADE_STEP_CYCLES
) (
  input  wire logic sys_clk_in,  // System clock
  input  wire logic reset_in,    // Synchronous reset, high
  input  wire logic enable_in,   // Fade while high
  output logic      led_out      // PWM LED drive
);

  typedef struct packed {
    logic [7:0]                        pwm;
    logic [7:0]                        level;
    logic                              up;
    logic [boot_select_pkg::FADE_W-1:0] step;
    logic                              led;
  } fade_s;

  fade_s q, d;

  // Ramp level up then down; PWM compares against it
  always_comb begin
    d = q;
    d.pwm = q.pwm + 8'h01;
    if (q.step == '0) begin
      d.step = boot_select_pkg::FADE_W'(STEP_CYCLES - 1);
      if (q.up) begin
        if (q.level == boot_select_pkg::LEVEL_MAX) begin
          d.up = 1'b0;
        end else begin
          d.level = q.level + 8'h01;
        end
      end else begin
        if (q.level == boot_select_pkg::LEVEL_MIN) begin
          d.up = 1'b1;
        end else begin
          d.level = q.level - 8'h01;
        end
      end
    end else begin
      d.step = q.step - 1'b1;
    end
    d.led = (q.pwm < q.level);
    // Dark and rewound when idle, so each loader entry fades in from zero
    if (!enable_in) begin
      d = '0;
      d.up = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      q <= '0;
      q.up <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign led_out = q.led;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  led_dark_idle_a: assert property (!enable_in |=> !led_out)
    else $error("LED lit while fading is disabled");

endmodule

// ==== tb/reset_host_model.sv ====
/*
  Behavioural model of the reset button and the programming host.
  Assumes its tasks are called from the bench's main sequence.
*/
`timescale 1ns/100ps
module reset_host_model #(
  parameter int unsigned HOLD_CYCLES = 12
) (
  input  wire logic sys_clk_in,      // System clock
  output logic      ext_reset_n_out, // Button line, pulled high
  output logic      cmd_start_out    // Command start pulse
);
  // Button released and host silent at power-up
  initial begin
    ext_reset_n_out = 1'b1;
    cmd_start_out   = 1'b0;
  end

  // whole press
  // Low and high both outlast the filter, so one press is one count
  task automatic press();
    @(posedge sys_clk_in);
    ext_reset_n_out <= 1'b0;
    repeat (HOLD_CYCLES) @(posedge sys_clk_in);
    ext_reset_n_out <= 1'b1;
    repeat (HOLD_CYCLES) @(posedge sys_clk_in);
  endtask

  task automatic send_cmd();
    @(posedge sys_clk_in);
    cmd_start_out <= 1'b1;
    @(posedge sys_clk_in);
    cmd_start_out <= 1'b0;
  endtask
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the boot selector with shortened counts.
  Assumes the reset button and host model drive the pin and commands.
*/
`timescale 1ns/100ps
module testbench;
  localparam int unsigned WIN = 40;
  localparam int unsigned LDR = 80;
  typedef struct {
    int   presses;
    logic valid;
    logic cmd;
    int   waitc;
    logic user;
    logic ldr;
  } row_s;

  logic        sys_clk, reset = 1'b1, por = 1'b1, ext_n, cmd;
  logic        ldr_exit = 1'b0, valid = 1'b1, bo_ev = 1'b0, bo_clr = 1'b0;
  logic        hold, run_user, loader, usb_en, led, bo_flag;
  logic [14:0] base;
  logic [1:0]  ports;
  int          n_errors = 0;
  int          checks_done = 0;
  int          ones;
  // Presses, image valid, command, wait, expected user, expected loader
  row_s rows [5] = '{'{1, 1'b1, 1'b0, 45, 1'b1, 1'b0}, '{2, 1'b1, 1'b0, 5, 1'b0, 1'b1},
                     '{0, 1'b1, 1'b0, 100, 1'b1, 1'b0}, '{2, 1'b1, 1'b1, 100, 1'b0, 1'b1},
                     '{2, 1'b0, 1'b0, 200, 1'b0, 1'b1}};

  boot_select #(.WINDOW_CYCLES(WIN), .LOADER_CYCLES(LDR), .DEBOUNCE_CYCLES(4),
                .FADE_CYCLES(2)) boot_select_i (
    .sys_clk_in(sys_clk), .reset_in(reset), .power_on_reset_in(por),
    .ext_reset_n_in(ext_n), .cmd_start_in(cmd), .loader_exit_in(ldr_exit),
    .user_program_valid_in(valid), .brownout_event_in(bo_ev),
    .brownout_clear_in(bo_clr), .cpu_hold_out(hold), .run_user_out(run_user),
    .loader_active_out(loader), .fetch_base_out(base), .serial_port_count_out(ports),
    .usb_serial_enable_out(usb_en), .led_out(led), .brownout_reset_flag_out(bo_flag));

  reset_host_model reset_host_model_i (
    .sys_clk_in(sys_clk), .ext_reset_n_out(ext_n), .cmd_start_out(cmd));

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Sixteen-cycle reset; por also clears the brown-out cause
  task automatic do_reset(input logic p);
    @(posedge sys_clk);
    reset <= 1'b1;
    por   <= p;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    por   <= 1'b0;
  endtask

  // One-cycle strobe: exit (0), brown-out event (1) or user clear (2)
  task automatic pulse(input int sel);
    @(posedge sys_clk);
    case (sel)
      0: ldr_exit <= 1'b1;
      1: bo_ev    <= 1'b1;
      default: bo_clr <= 1'b1;
    endcase
    @(posedge sys_clk);
    ldr_exit <= 1'b0;
    bo_ev    <= 1'b0;
    bo_clr   <= 1'b0;
    #1;
  endtask

  // Count LED-on cycles; a fade is neither always on nor always off
  task automatic led_ones(input int n);
    ones = 0;
    repeat (n) begin
      @(posedge sys_clk);
      // An unknown LED level counts as lit, so it cannot pass as dark
      #1 ones += (led !== 1'b0);
    end
  endtask

  // Main sequence: rows first, then the awkward cases
  initial begin
    do_reset(1'b1);
    repeat (2) @(posedge sys_clk);
    #1 check(hold, 1'b1);                                    // held in window
    check(run_user, 1'b0);                                   // no user code yet
    repeat (WIN + 10) @(posedge sys_clk);
    #1 check(run_user, 1'b1);                                // window then user
    check(bo_flag, 1'b0);                                    // clear after power-on
    foreach (rows[i]) begin
      @(posedge sys_clk);
      valid <= rows[i].valid;
      repeat (rows[i].presses) reset_host_model_i.press();
      if (rows[i].cmd) reset_host_model_i.send_cmd();
      repeat (rows[i].waitc) @(posedge sys_clk);
      #1 check(run_user, rows[i].user);
      check(loader, rows[i].ldr);
      check(hold, !rows[i].user);                            // held unless user
      check(usb_en, rows[i].ldr);                            // port enable
      check(ports, rows[i].ldr ? boot_select_pkg::LOADER_PORTS
                               : boot_select_pkg::NO_PORTS); // one port
      check(base, rows[i].ldr ? boot_select_pkg::LOADER_BASE
                              : boot_select_pkg::USER_BASE); // memory split
    end
    // Exit refused without an image, taken with one
    pulse(0);
    repeat (3) @(posedge sys_clk);
    #1 check(loader, 1'b1);                                  // exit refused
    led_ones(600);
    check(ones > 0 && ones < 600, 1'b1);                     // LED fades
    @(posedge sys_clk);
    valid <= 1'b1;
    pulse(0);
    repeat (2) @(posedge sys_clk);
    #1 check(run_user, 1'b1);                                // exit to user
    led_ones(300);
    check(ones, 16'h0000);                                   // dark outside loader
    // Brown-out cause survives an ordinary reset and the startup window
    pulse(1);
    check(bo_flag, 1'b1);                                    // flag set
    do_reset(1'b0);
    repeat (WIN + 20) @(posedge sys_clk);
    #1 check(bo_flag, 1'b1);                                 // startup keeps flag
    check(run_user, 1'b1);                                   // user after window
    @(posedge sys_clk);
    bo_ev  <= 1'b1;
    bo_clr <= 1'b1;
    @(posedge sys_clk);
    bo_ev  <= 1'b0;
    bo_clr <= 1'b0;
    @(posedge sys_clk);
    #1 check(bo_flag, 1'b1);                                 // set wins
    pulse(2);
    @(posedge sys_clk);
    #1 check(bo_flag, 1'b0);                                 // user clears
    // Power-on clears the cause; an empty image after the window means loader
    pulse(1);
    @(posedge sys_clk);
    valid <= 1'b0;
    do_reset(1'b1);
    repeat (WIN + 20) @(posedge sys_clk);
    #1 check(bo_flag, 1'b0);                                 // power-on clears
    check(loader, 1'b1);                                     // empty image stays
    check(run_user, 1'b0);                                   // no user start
    close_out();
  end

  // Watchdog: the sequence needs about 1800 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end
endmodule
